// File: hw/mfm_pkg.sv
/*
  mfm_pkg: constants, register map, enumerations and carrier types of
  the motor driver fault manager.
  Assumes a 100 MHz core clock; the analog detectors sit outside.
*/
// Summary of operation
// - Without soft ramp, inrush field maps 5 ms at 0000h to 6.7 s at FFFFh.
// - Stall detection is blanked for the whole inrush time after motor start.
// - With soft ramp in regulation, target ramps over field plus one times setpoint ticks.
// - Current limit held past deglitch disables bridge, sets bits, pulls pin.
// - Overcurrent select 0b latches off, 1b retries automatically.
// - Retry keeps bridge off and pin low for retry time, then repeats.
// - Latch-off holds bridge off and pin low until clear or power cycle.
// - Overcurrent is sensed per transistor, apart from regulation sensing.
// - Overtemperature disables bridge, sets bits, pulls pin; select picks mode.
// - Thermal auto mode resumes below hysteresis; thermal bit stays until clear.
// - Thermal latch mode resumes after cooling plus clear command or power cycle.
// - Undervoltage floats outputs, stops charge pump, pulls pin low.
// - Undervoltage sets summary and sticky bit; recovery clears summary only.
// - At power-up summary is set, pin low, until supply passes threshold.
// - Outputs above supply while idle turn both low sides on to brake.
// - Overvoltage braking on after power-up; its enable survives sleep.
// - High current while braking switches the low sides off.
// - Fault pin is open drain, low whenever a fault is present.
// - Active mode needs supply good, sleep pin high for wake time, enable.
// - Sleep pin low for turn-off time enters sleep with outputs floating.
// - Fault mode ends as soon as the active fault recovers.
package mfm_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_NS = 10;

  function automatic int cyc_up(input longint t_ns);
    return int'((t_ns + CLK_NS - 1) / CLK_NS);
  endfunction

  localparam longint INR_MIN_NS = 5000000;
  localparam longint INR_MAX_NS = 64'd6700000000;
  localparam int INR_CODES = 65535;
  localparam longint INR_STEP_NS = (INR_MAX_NS - INR_MIN_NS) / INR_CODES;
  localparam int INR_STEP_CYC = int'(INR_STEP_NS / CLK_NS);
  localparam int INR_BASE_TICKS =
    int'((INR_MIN_NS + INR_STEP_NS - 1) / INR_STEP_NS);
  // code for about 1 s
  localparam logic [15:0] INR_RST = 16'h260C;
  localparam longint OCP_DEG_NS = 2000;
  localparam int OCP_DEG_CYC = cyc_up(OCP_DEG_NS);
  localparam longint RETRY_NS = 4000000;
  localparam int RETRY_CYC = cyc_up(RETRY_NS);
  localparam longint WAKE_NS = 1000000;
  localparam int WAKE_CYC = cyc_up(WAKE_NS);
  localparam longint TURNOFF_NS = 1000000;
  localparam int TURNOFF_CYC = cyc_up(TURNOFF_NS);
  localparam int CNT_W = 24;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CLR = 8'h01;
  localparam logic [7:0] REG_INR = 8'h02;
  localparam logic [7:0] REG_SETPT = 8'h03;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CLR_BIT = 0;
  localparam logic [7:0] SETPT_RST = 8'h00;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef struct packed {
    logic th_sel;
    logic oc_sel;
    logic en_ss;
    logic overvoltage_enable;
    logic en_out;
  } mfm_cfg_t;
  // overvoltage braking enabled, all else off
  localparam mfm_cfg_t CFG_RST = 5'h02;

  typedef struct packed {
    logic fpin;
    logic boc;
    logic ov;
    logic vm_ok;
    logic warm;
    logic hot;
    logic [3:0] oc;
    logic [1:0] drive;
    logic sleep_n;
  } mfm_pins_t;

  typedef struct packed {
    logic [5:0] rsvd;
    logic por;
    logic fpin;
    logic sum;
    logic brake;
    logic blank;
    logic oc;
    logic th;
    logic uv;
    logic [1:0] mode;
  } mfm_stat_t;

  typedef enum logic [1:0] {
    M_SLEEP = 2'h0,
    M_STBY = 2'h1,
    M_ACT = 2'h3,
    M_FLT = 2'h2
  } mfm_mode_t;

  typedef enum logic [1:0] {
    OC_OK = 2'h0,
    OC_RTY = 2'h1,
    OC_LAT = 2'h3
  } mfm_oc_t;

  // gate enables {hs1, ls1, hs2, ls2}
  localparam logic [3:0] G_OFF = 4'h0;
  localparam logic [3:0] G_FWD = 4'h9;
  localparam logic [3:0] G_REV = 4'h6;
  localparam logic [3:0] G_BRK = 4'h5;

endpackage

// File: hw/mfm_sync.sv
/*
  mfm_sync: two-stage synchroniser for a vector of asynchronous levels.
  Assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/10ps
module mfm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // levels in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // mfm_sync

// File: hw/mfm_dly.sv
/*
  mfm_dly: qualifying counter; done rises once run has stood for
  limit consecutive cycles and stays while run stays.
  Assumes run and limit come from the same clock domain.
*/
`timescale 1ns/10ps
module mfm_dly (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // qualify
  input wire logic run,
  input wire logic [mfm_pkg::CNT_W-1:0] limit,
  output logic done
);
  logic [mfm_pkg::CNT_W-1:0] cnt_r;

  // count saturates so a long hold never wraps
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (!run) begin
      cnt_r <= '0;
    end else if (!done) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign done = run && (cnt_r >= limit);
endmodule // mfm_dly

// File: hw/mfm_top.sv
/*
  mfm_top: fault and operating-mode manager of an H-bridge driver.
  Holds inrush timing, soft ramp, overcurrent, thermal, undervoltage
  and overvoltage-brake handling, modes and the open-drain fault pin.
  Assumes analog detectors give levels on asynchronous pins and a
  register master on the core clock.
*/
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module mfm_top #(
  parameter int INR_STEP_CYC = mfm_pkg::INR_STEP_CYC,
  parameter int RETRY_CYC = mfm_pkg::RETRY_CYC,
  parameter int WAKE_CYC = mfm_pkg::WAKE_CYC,
  parameter int TURNOFF_CYC = mfm_pkg::TURNOFF_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // asynchronous pins and detectors
  input wire logic sleep_pin_n,
  input wire logic [1:0] drive_in,
  input wire logic [3:0] oc_limit,
  input wire logic ot_hot,
  input wire logic ot_warm,
  input wire logic vm_ok,
  input wire logic ov_sense,
  input wire logic brake_oc,
  // regulation loop context
  input wire logic reg_on,
  // bridge control
  output logic [3:0] gate_en,
  output logic hiz,
  output logic cp_en,
  output logic stall_blank,
  output logic [7:0] ramp_target,
  // open-drain fault pin
  input wire logic fault_pin_n_i,
  output logic fault_pin_n_o,
  output logic fault_pin_n_oe_n
);
  mfm_pkg::mfm_pins_t pins;
  mfm_pkg::mfm_cfg_t cfg_r;
  mfm_pkg::mfm_mode_t mode_r, mode_nxt;
  mfm_pkg::mfm_oc_t oc_r;
  mfm_pkg::mfm_stat_t stat;
  logic [15:0] inr_r;
  logic [7:0] setpt_r, goal;
  logic [23:0] pre_r;
  logic [16:0] tck_r;
  logic [15:0] stp_r;
  logic awake_r, por_r, th_act_r, oc_bit_r, th_bit_r, uv_bit_r;
  logic boc_r, run_r, blank_r;
  logic wake_done, off_done, deg_done, rty_done;
  logic clr, uv, faulted, sum, drv_ok, driving, start, brake;
  logic ss, tick, step;

  function automatic logic hit(input logic [7:0] a);
    return reg_addr == a;
  endfunction

  // ***********************************************************
  // input synchronisers and timers
  // ***********************************************************
  mfm_sync #(.W($bits(mfm_pkg::mfm_pins_t))) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({fault_pin_n_i, brake_oc, ov_sense, vm_ok, ot_warm, ot_hot,
        oc_limit, drive_in, sleep_pin_n}),
    .q(pins)
  );

  mfm_dly u_wake (
    .clock(clock),
    .nrst(nrst),
    .run(pins.sleep_n && !awake_r),
    .limit(24'(WAKE_CYC)),
    .done(wake_done)
  );

  mfm_dly u_off (
    .clock(clock),
    .nrst(nrst),
    .run(!pins.sleep_n && awake_r),
    .limit(24'(TURNOFF_CYC)),
    .done(off_done)
  );

  mfm_dly u_deg (
    .clock(clock),
    .nrst(nrst),
    .run((|pins.oc) && oc_r == mfm_pkg::OC_OK),
    .limit(24'(mfm_pkg::OCP_DEG_CYC)),
    .done(deg_done)
  );

  mfm_dly u_rty (
    .clock(clock),
    .nrst(nrst),
    .run(oc_r == mfm_pkg::OC_RTY),
    .limit(24'(RETRY_CYC)),
    .done(rty_done)
  );

  // ***********************************************************
  // registers
  // ***********************************************************
  // one-shot clear
  assign clr = reg_wr && hit(mfm_pkg::REG_CLR) && reg_wdata[mfm_pkg::CLR_BIT];

  // sleep wipes the configuration but the braking enable
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= mfm_pkg::CFG_RST;
    end else if (mode_r == mfm_pkg::M_SLEEP) begin
      cfg_r <= '{overvoltage_enable: cfg_r.overvoltage_enable, default: 1'b0};
    end else if (reg_wr && hit(mfm_pkg::REG_CTRL)) begin
      cfg_r <= reg_wdata[$bits(mfm_pkg::mfm_cfg_t)-1:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      inr_r <= mfm_pkg::INR_RST;
      setpt_r <= mfm_pkg::SETPT_RST;
    end else begin
      if (reg_wr && hit(mfm_pkg::REG_INR)) begin
        inr_r <= reg_wdata;
      end
      if (reg_wr && hit(mfm_pkg::REG_SETPT)) begin
        setpt_r <= reg_wdata[7:0];
      end
    end
  end

  always_comb begin
    stat = '0;
    stat.por = por_r;
    stat.fpin = pins.fpin;
    stat.sum = sum;
    stat.brake = brake;
    stat.blank = stall_blank;
    stat.oc = oc_bit_r;
    stat.th = th_bit_r;
    stat.uv = uv_bit_r;
    stat.mode = mode_r;
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        mfm_pkg::REG_CTRL: reg_rdata <= 16'(cfg_r);
        mfm_pkg::REG_INR: reg_rdata <= inr_r;
        mfm_pkg::REG_SETPT: reg_rdata <= {8'h00, setpt_r};
        mfm_pkg::REG_STAT: reg_rdata <= stat;
        default: reg_rdata <= '0;
      endcase
    end
  end

  // ***********************************************************
  // fault tracking
  // ***********************************************************
  assign uv = !pins.vm_ok;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      por_r <= 1'b1;
    end else if (pins.vm_ok) begin
      por_r <= 1'b0;
    end
  end

  // sticky bits: a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      uv_bit_r <= 1'b0;
      oc_bit_r <= 1'b0;
      th_bit_r <= 1'b0;
    end else begin
      if (uv && !por_r) begin
        uv_bit_r <= 1'b1;
      end else if (clr) begin
        uv_bit_r <= 1'b0;
      end
      if (deg_done) begin
        oc_bit_r <= 1'b1;
      end else if (clr) begin
        oc_bit_r <= 1'b0;
      end
      if (pins.hot) begin
        th_bit_r <= 1'b1;
      end else if (clr) begin
        th_bit_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oc_r <= mfm_pkg::OC_OK;
    end else begin
      case (oc_r)
        mfm_pkg::OC_OK: begin
          if (deg_done) begin
            oc_r <= cfg_r.oc_sel ? mfm_pkg::OC_RTY : mfm_pkg::OC_LAT;
          end
        end
        mfm_pkg::OC_RTY: begin
          if (rty_done) begin
            oc_r <= mfm_pkg::OC_OK;
          end
        end
        mfm_pkg::OC_LAT: begin
          if (clr) begin
            oc_r <= mfm_pkg::OC_OK;
          end
        end
        default: oc_r <= mfm_pkg::OC_OK;
      endcase
    end
  end

  // a clear sent while still hot is lost; cool first, then clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      th_act_r <= 1'b0;
    end else if (pins.hot) begin
      th_act_r <= 1'b1;
    end else if (!pins.warm && (cfg_r.th_sel || clr)) begin
      th_act_r <= 1'b0;
    end
  end

  // fault lasts while a cause lasts
  assign faulted = uv || oc_r != mfm_pkg::OC_OK || th_act_r;
  assign sum = por_r || faulted;

  // ***********************************************************
  // operating mode
  // ***********************************************************
  // sleep qualification
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awake_r <= 1'b0;
    end else if (wake_done) begin
      awake_r <= 1'b1;
    end else if (off_done) begin
      awake_r <= 1'b0;
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      mfm_pkg::M_SLEEP: begin
        if (awake_r) begin
          mode_nxt = mfm_pkg::M_STBY;
        end
      end
      mfm_pkg::M_STBY, mfm_pkg::M_ACT, mfm_pkg::M_FLT: begin
        if (!awake_r) begin
          mode_nxt = mfm_pkg::M_SLEEP;
        end else if (faulted) begin
          mode_nxt = mfm_pkg::M_FLT;
        end else if (cfg_r.en_out && pins.vm_ok) begin
          mode_nxt = mfm_pkg::M_ACT;
        end else begin
          mode_nxt = mfm_pkg::M_STBY;
        end
      end
      default: mode_nxt = mfm_pkg::M_SLEEP;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_r <= mfm_pkg::M_SLEEP;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ***********************************************************
  // bridge and pin
  // ***********************************************************
  // faulted also gates the drive so a trip turns the gates off on the same edge as the mode moves
  assign drv_ok = mode_r == mfm_pkg::M_ACT && !faulted;
  assign driving = drv_ok && pins.drive != 2'h0;
  assign brake = !driving && cfg_r.overvoltage_enable && pins.ov && !boc_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      boc_r <= 1'b0;
    end else if (brake && pins.boc) begin
      boc_r <= 1'b1;
    end else if (!pins.ov) begin
      boc_r <= 1'b0;
    end
  end

  assign fault_pin_n_o = 1'b0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_en <= mfm_pkg::G_OFF;
      hiz <= 1'b1;
      cp_en <= 1'b0;
      fault_pin_n_oe_n <= 1'b1;
    end else begin
      if (brake) begin
        gate_en <= mfm_pkg::G_BRK;
      end else if (!drv_ok) begin
        gate_en <= mfm_pkg::G_OFF;
      end else begin
        case (pins.drive)
          2'h2: gate_en <= mfm_pkg::G_FWD;
          2'h1: gate_en <= mfm_pkg::G_REV;
          2'h3: gate_en <= mfm_pkg::G_BRK;
          default: gate_en <= mfm_pkg::G_OFF;
        endcase
      end
      hiz <= !driving && !brake;
      cp_en <= !uv && awake_r;
      fault_pin_n_oe_n <= !sum;
    end
  end

  // ***********************************************************
  // inrush timing and soft ramp
  // ***********************************************************
  assign start = driving && !run_r;
  assign tick = pre_r == 24'(INR_STEP_CYC - 1);
  assign ss = cfg_r.en_ss && reg_on;
  assign goal = driving ? setpt_r : 8'h00;
  assign step = tick && stp_r >= inr_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_r <= 1'b0;
      pre_r <= '0;
      stp_r <= '0;
    end else begin
      run_r <= driving;
      pre_r <= (start || tick) ? '0 : pre_r + 1'b1;
      if (tick) begin
        stp_r <= step ? '0 : stp_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      blank_r <= 1'b0;
      tck_r <= '0;
    end else if (start) begin
      blank_r <= 1'b1;
      tck_r <= '0;
    end else if (!driving) begin
      blank_r <= 1'b0;
    end else if (blank_r && tick) begin
      if (tck_r + 17'h00001 >=
          {1'b0, inr_r} + 17'(mfm_pkg::INR_BASE_TICKS)) begin
        blank_r <= 1'b0;
      end else begin
        tck_r <= tck_r + 1'b1;
      end
    end
  end

  // one setpoint unit per field plus one ticks
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ramp_target <= '0;
      stall_blank <= 1'b0;
    end else begin
      if (!ss) begin
        ramp_target <= goal;
      end else if (step && ramp_target < goal) begin
        ramp_target <= ramp_target + 1'b1;
      end else if (step && ramp_target > goal) begin
        ramp_target <= ramp_target - 1'b1;
      end
      stall_blank <= blank_r || (ss && ramp_target != goal);
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_trip;
    $rose(deg_done) |=> oc_bit_r && oc_r != mfm_pkg::OC_OK
      ##1 !fault_pin_n_oe_n && gate_en[3] == 1'b0;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not taken");

  property p_sel;
    deg_done && cfg_r.oc_sel |=> oc_r == mfm_pkg::OC_RTY;
  endproperty
  a_sel: assert property (p_sel) else $error("wrong recovery");

  property p_rty;
    $rose(oc_r == mfm_pkg::OC_RTY) |-> (oc_r == mfm_pkg::OC_RTY)[*8];
  endproperty
  a_rty: assert property (p_rty) else $error("retry too short");

  property p_lat;
    oc_r == mfm_pkg::OC_LAT && !clr |=> oc_r == mfm_pkg::OC_LAT
      && !fault_pin_n_oe_n;
  endproperty
  a_lat: assert property (p_lat) else $error("latch lost");

  property p_th;
    th_act_r && cfg_r.th_sel && !pins.hot && !pins.warm
      |=> !th_act_r && th_bit_r;
  endproperty
  a_th: assert property (p_th) else $error("thermal resume");

  property p_uv;
    uv && !por_r |=> uv_bit_r && !fault_pin_n_oe_n && !cp_en;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage");

  property p_por;
    // skip the release edge, where the pin flop still sat in reset
    por_r && $past(nrst) |=> !fault_pin_n_oe_n;
  endproperty
  a_por: assert property (p_por) else $error("power-up pin");

  property p_brk;
    brake |=> gate_en == mfm_pkg::G_BRK && !hiz;
  endproperty
  a_brk: assert property (p_brk) else $error("no brake");

  property p_act;
    $rose(mode_r == mfm_pkg::M_ACT) |-> $past(cfg_r.en_out)
      && $past(pins.vm_ok) && awake_r;
  endproperty
  a_act: assert property (p_act) else $error("bad active");

  property p_blank;
    start |=> blank_r ##1 stall_blank;
  endproperty
  a_blank: assert property (p_blank) else $error("no blanking");

endmodule // mfm_top

// File: tb/mfm_host.sv
/*
  mfm_host: host side of the open-drain fault line, with the board
  pull-up. Assumes the device releases the pin by raising its oe_n.
*/
`timescale 1ns/10ps
module mfm_host (
  // device pin
  input wire logic pin_o,
  input wire logic pin_oe_n,
  // line seen by the host and fed back to the device
  output logic line
);
  // pull-up when released
  // a released line never shows the last driven level
  assign line = pin_oe_n ? 1'h1 : pin_o;
endmodule // mfm_host

// File: tb/tb_top.sv
/*
  tb_top: self-checking bench of mfm_top with shortened counts.
  Assumes the host model pulls the fault line up when released.
*/
`timescale 1ns/10ps
module tb_top;
  localparam int STEP = 4;
  localparam int RETRY = 50;
  localparam int WAKE = 20;
  localparam int LIMIT_NS = 200000;
  logic clock = 0;
  logic nrst = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [15:0] reg_rdata;
  logic sleep_pin_n = 1;
  logic [1:0] drive_in = 2'h0;
  logic [3:0] oc_limit = 4'h0;
  logic ot_hot = 0;
  logic ot_warm = 0;
  logic vm_ok = 0;
  logic ov_sense = 0;
  logic brake_oc = 0;
  logic reg_on = 0;
  logic [3:0] gate_en;
  logic hiz, cp_en, stall_blank, pin_o, pin_oe_n;
  wire logic line;
  logic [7:0] ramp_target;
  int fails = 0;
  int compares = 0;

  always #5 clock = ~clock;

  mfm_top #(.INR_STEP_CYC(STEP), .RETRY_CYC(RETRY), .WAKE_CYC(WAKE),
    .TURNOFF_CYC(WAKE)) dut (.clock, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .sleep_pin_n, .drive_in, .oc_limit,
    .ot_hot, .ot_warm, .vm_ok, .ov_sense, .brake_oc, .reg_on, .gate_en,
    .hiz, .cp_en, .stall_blank, .ramp_target, .fault_pin_n_i(line),
    .fault_pin_n_o(pin_o), .fault_pin_n_oe_n(pin_oe_n));
  mfm_host host (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .line(line));

  // ***********************************************************
  // bus cycles and compares
  // ***********************************************************
  // w settles 1 ns past the edge so outputs are stable when looked at
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic rg(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic sb(input int b, input logic e);
    logic [15:0] d;
    rd(mfm_pkg::REG_STAT, d);
    chk(d[b], e);
  endtask
  task automatic md(input logic [1:0] e);
    logic [15:0] d;
    rd(mfm_pkg::REG_STAT, d);
    chk(d[1:0], e);
  endtask

  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic t_power;
    chk(line, 1'h0);
    sb(7, 1'h1);
    sb(2, 1'h0);
    sb(9, 1'h1);
    rg(mfm_pkg::REG_CTRL, 16'h0002);
    rg(mfm_pkg::REG_INR, 16'h260C);
    rg(8'h3F, 16'h0000);
    @(posedge clock) vm_ok <= 1'h1;
    w(40);
    chk(line, 1'h1);
    sb(9, 1'h0);
    md(mfm_pkg::M_STBY);
    wr(mfm_pkg::REG_CTRL, 16'h0003);
    wr(mfm_pkg::REG_INR, 16'h0000);
    w(3);
    md(mfm_pkg::M_ACT);
    chk(cp_en, 1'h1);
  endtask
  task automatic t_inrush;
    @(posedge clock) drive_in <= 2'h2;
    w(8);
    chk(gate_en, mfm_pkg::G_FWD);
    chk(stall_blank, 1'h1);
    w(180);
    chk(stall_blank, 1'h1);
    w(15);
    chk(stall_blank, 1'h0);
  endtask
  task automatic t_ramp;
    wr(mfm_pkg::REG_CTRL, 16'h0007);
    wr(mfm_pkg::REG_SETPT, 16'h0008);
    @(posedge clock) drive_in <= 2'h0;
    reg_on <= 1'h1;
    w(60);
    @(posedge clock) drive_in <= 2'h2;
    w(12);
    chk(ramp_target == 8'h08, 1'h0);
    w(60);
    chk(ramp_target, 8'h08);
    @(posedge clock) drive_in <= 2'h0;
    w(12);
    chk(ramp_target == 8'h00, 1'h0);
    w(60);
    chk(ramp_target, 8'h00);
    @(posedge clock) reg_on <= 1'h0;
    drive_in <= 2'h2;
    wr(mfm_pkg::REG_CTRL, 16'h000B);
    w(20);
  endtask
  task automatic t_oc_retry;
    @(posedge clock) oc_limit <= 4'h8;
    w(150);
    @(posedge clock) oc_limit <= 4'h0;
    w(5);
    chk(gate_en, mfm_pkg::G_FWD);
    @(posedge clock) oc_limit <= 4'h1;
    w(210);
    chk(gate_en, mfm_pkg::G_OFF);
    chk(line, 1'h0);
    sb(4, 1'h1);
    @(posedge clock) oc_limit <= 4'h0;
    w(20);
    chk(gate_en, mfm_pkg::G_OFF);
    chk(line, 1'h0);
    w(40);
    chk(gate_en, mfm_pkg::G_FWD);
    chk(line, 1'h1);
  endtask
  task automatic t_oc_latch;
    wr(mfm_pkg::REG_CTRL, 16'h0003);
    @(posedge clock) oc_limit <= 4'h8;
    w(210);
    @(posedge clock) oc_limit <= 4'h0;
    w(100);
    chk(gate_en, mfm_pkg::G_OFF);
    chk(line, 1'h0);
    md(mfm_pkg::M_FLT);
    wr(mfm_pkg::REG_CLR, 16'h0001);
    w(4);
    chk(gate_en, mfm_pkg::G_FWD);
    chk(line, 1'h1);
    sb(4, 1'h0);
  endtask
  task automatic t_therm;
    wr(mfm_pkg::REG_CTRL, 16'h0013);
    @(posedge clock) ot_hot <= 1'h1;
    ot_warm <= 1'h1;
    w(5);
    chk(gate_en, mfm_pkg::G_OFF);
    chk(line, 1'h0);
    sb(3, 1'h1);
    @(posedge clock) ot_hot <= 1'h0;
    w(5);
    chk(gate_en, mfm_pkg::G_OFF);
    @(posedge clock) ot_warm <= 1'h0;
    w(5);
    chk(gate_en, mfm_pkg::G_FWD);
    sb(7, 1'h0);
    sb(3, 1'h1);
    wr(mfm_pkg::REG_CTRL, 16'h0003);
    @(posedge clock) ot_hot <= 1'h1;
    ot_warm <= 1'h1;
    w(5);
    @(posedge clock) ot_hot <= 1'h0;
    ot_warm <= 1'h0;
    w(20);
    chk(gate_en, mfm_pkg::G_OFF);
    wr(mfm_pkg::REG_CLR, 16'h0001);
    w(4);
    chk(gate_en, mfm_pkg::G_FWD);
    sb(3, 1'h0);
  endtask
  task automatic t_uv;
    @(posedge clock) vm_ok <= 1'h0;
    w(5);
    chk(hiz, 1'h1);
    chk(cp_en, 1'h0);
    chk(line, 1'h0);
    sb(2, 1'h1);
    sb(7, 1'h1);
    @(posedge clock) vm_ok <= 1'h1;
    w(5);
    chk(line, 1'h1);
    sb(7, 1'h0);
    sb(2, 1'h1);
    md(mfm_pkg::M_ACT);
    wr(mfm_pkg::REG_CLR, 16'h0001);
    sb(2, 1'h0);
    rg(mfm_pkg::REG_CLR, 16'h0000);
  endtask
  task automatic t_ov;
    @(posedge clock) drive_in <= 2'h1;
    w(5);
    chk(gate_en, mfm_pkg::G_REV);
    @(posedge clock) drive_in <= 2'h3;
    w(5);
    chk(gate_en, mfm_pkg::G_BRK);
    @(posedge clock) drive_in <= 2'h0;
    w(5);
    chk(hiz, 1'h1);
    @(posedge clock) ov_sense <= 1'h1;
    w(5);
    chk(gate_en, mfm_pkg::G_BRK);
    sb(6, 1'h1);
    @(posedge clock) brake_oc <= 1'h1;
    w(5);
    chk(gate_en, mfm_pkg::G_OFF);
    @(posedge clock) ov_sense <= 1'h0;
    brake_oc <= 1'h0;
    wr(mfm_pkg::REG_CTRL, 16'h0001);
    @(posedge clock) ov_sense <= 1'h1;
    w(5);
    chk(gate_en, mfm_pkg::G_OFF);
    @(posedge clock) ov_sense <= 1'h0;
  endtask
  task automatic t_sleep;
    @(posedge clock) sleep_pin_n <= 1'h0;
    w(10);
    @(posedge clock) sleep_pin_n <= 1'h1;
    w(5);
    md(mfm_pkg::M_ACT);
    @(posedge clock) sleep_pin_n <= 1'h0;
    w(30);
    md(mfm_pkg::M_SLEEP);
    chk(hiz, 1'h1);
    // refused while asleep
    wr(mfm_pkg::REG_CTRL, 16'h0003);
    @(posedge clock) sleep_pin_n <= 1'h1;
    w(30);
    md(mfm_pkg::M_STBY);
    rg(mfm_pkg::REG_CTRL, 16'h0000);
  endtask

  task automatic close_out;
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    w(19);
    @(posedge clock) nrst <= 1'h1;
    w(2);
    t_power;
    t_inrush;
    t_ramp;
    t_oc_retry;
    t_oc_latch;
    t_therm;
    t_uv;
    t_ov;
    t_sleep;
    close_out;
  end

  // the run needs about 1500 cycles; the limit leaves wide margin
  initial begin
    #(LIMIT_NS);
    fails++;
    close_out;
  end
endmodule // tb_top
